// file: hw/spi_cfg_pkg.sv
/*
 * Constants for the serial configuration port: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 100 MHz system clock.
 */
package spi_cfg_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 4;
    localparam int GAP_W  = 8;
    localparam int RECOV_W = 20;

    localparam logic [ADDR_W-1:0] ADDR_CFG_A       = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_CFG_B       = 15'h0001;
    localparam logic [ADDR_W-1:0] ADDR_CHIP_CFG    = 15'h0002;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_IDX    = 15'h0008;
    localparam logic [ADDR_W-1:0] ADDR_SAMPLE_MODE = 15'h0561;

    localparam int CFGA_SOFT_RST   = 0;
    localparam int CFGA_LSB        = 1;
    localparam int CFGA_ASC        = 2;
    localparam int CFGA_ASC_MIR    = 5;
    localparam int CFGA_LSB_MIR    = 6;
    localparam int CFGA_SOFT_RST_M = 7;
    localparam int CFGB_DP_RST     = 1;
    localparam int CHAN_A_BIT      = 0;
    localparam int CHAN_B_BIT      = 1;
    localparam int PWR_LO          = 0;
    localparam int PWR_HI          = 1;

    localparam logic [DATA_W-1:0] SAMPLE_MODE_RST = 8'h01;
    localparam logic              CHAN_A_RST      = 1'b1;
    localparam logic              CHAN_B_RST      = 1'b1;
    localparam logic              READ_FLAG       = 1'b1;

    localparam logic [CNT_W-1:0] INSTR_LAST = 4'hf;
    localparam logic [CNT_W-1:0] BYTE_LAST  = 4'h7;

    localparam int CLK_PERIOD_NS = 10;
    localparam int RECOVERY_MS   = 5;
    localparam int FRAME_GAP_NS  = 1000;
    localparam int RECOVERY_CYCLES_DFLT = (RECOVERY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [GAP_W-1:0] FRAME_GAP_CYCLES = GAP_W'((FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// file: hw/spi_config_port.sv
/*
 * Three-wire serial configuration port with its register file.
 * Registers live on clk_sys; the shifters run on the serial clock.
 * Assumes the host leaves the pauses listed for read turnaround.
 */
`timescale 1ns/1ns
module spi_config_port #(
    parameter int RECOVERY_CYCLES = spi_cfg_pkg::RECOVERY_CYCLES_DFLT
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic                       sclk,
    input  wire logic                       port_select_n,
    input  wire logic                       sdioIn,
    output logic                            sdioOut,
    output logic                            sdioOe,
    output logic                            secondaryEn,
    output logic                            recoveryBusy,
    output logic                            datapathReset,
    output logic [spi_cfg_pkg::DATA_W-1:0]  sampleMode,
    output logic [1:0]                      powerModeA,
    output logic [1:0]                      powerModeB
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic               csbS1;
        logic               csbS2;
        logic               reqS1;
        logic               reqS2;
        logic               reqSeen;
        logic [GAP_W-1:0]   idleCnt;
        logic               linkHold;
        logic               secondaryEn;
        logic               lsbFirst;
        logic               ascend;
        logic               chanA;
        logic               chanB;
        logic [1:0][1:0]    powerMode;
        logic [DATA_W-1:0]  sampleMode;
        logic               dpReset;
        logic               recovering;
        logic [RECOV_W-1:0] recovCnt;
        logic [DATA_W-1:0]  rdData;
    } core_state_t;

    // Select synchroniser starts at the idle level, so reset is not taken as a frame start
    localparam core_state_t CORE_RST = '{
        csbS1:       1'b1,
        csbS2:       1'b1,
        linkHold:    1'b1,
        secondaryEn: 1'b1,
        chanA:       CHAN_A_RST,
        chanB:       CHAN_B_RST,
        sampleMode:  SAMPLE_MODE_RST,
        default:     '0
    };

    spi_link_if lk ();

    core_state_t       s;
    core_state_t       next_s;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] wd;
    logic              linkRstN;
    logic              txRstN;

    // Readback of the addressed register
    always_comb begin
        rd = '0;
        unique case (lk.reqAddr)
            ADDR_CFG_A: begin
                rd[CFGA_LSB]     = s.lsbFirst;
                rd[CFGA_LSB_MIR] = s.lsbFirst;
                rd[CFGA_ASC]     = s.ascend;
                rd[CFGA_ASC_MIR] = s.ascend;
            end
            ADDR_CHIP_CFG: begin
                rd[1:0] = (s.chanA || !s.chanB) ? s.powerMode[PWR_LO] : s.powerMode[PWR_HI];
            end
            ADDR_CHAN_IDX: begin
                rd[CHAN_A_BIT] = s.chanA;
                rd[CHAN_B_BIT] = s.chanB;
            end
            ADDR_SAMPLE_MODE: begin
                rd = s.sampleMode;
            end
            default: begin
                rd = '0;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        wd = lk.reqData;
        next_s.csbS1 = port_select_n;
        next_s.csbS2 = s.csbS1;
        next_s.reqS1 = lk.reqTgl;
        next_s.reqS2 = s.reqS1;
        next_s.dpReset = 1'b0;

        // Long select-high idle ends the frame and hands the pins over
        if (s.csbS2) begin
            if (s.idleCnt != FRAME_GAP_CYCLES) begin
                next_s.idleCnt = s.idleCnt + 8'h01;
            end else begin
                next_s.linkHold = 1'b1;
                next_s.secondaryEn = 1'b1;
            end
        end else begin
            next_s.idleCnt = '0;
            next_s.secondaryEn = 1'b0;
            next_s.linkHold = s.recovering;
        end

        if (s.recovering) begin
            if (s.recovCnt == '0) begin
                next_s.recovering = 1'b0;
            end else begin
                next_s.recovCnt = s.recovCnt - 20'h00001;
            end
        end

        if (s.reqS2 != s.reqSeen) begin
            next_s.reqSeen = s.reqS2;
            if (!lk.reqWrite) begin
                next_s.rdData = rd;
            end else if (!s.recovering) begin
                unique case (lk.reqAddr)
                    ADDR_CFG_A: begin
                        if (wd[CFGA_SOFT_RST] || wd[CFGA_SOFT_RST_M]) begin
                            next_s.lsbFirst   = CORE_RST.lsbFirst;
                            next_s.ascend     = CORE_RST.ascend;
                            next_s.chanA      = CORE_RST.chanA;
                            next_s.chanB      = CORE_RST.chanB;
                            next_s.powerMode  = CORE_RST.powerMode;
                            next_s.sampleMode = CORE_RST.sampleMode;
                            next_s.rdData     = '0;
                            next_s.linkHold   = 1'b1;
                            next_s.recovering = 1'b1;
                            next_s.recovCnt   = RECOV_W'(RECOVERY_CYCLES - 1);
                        end else begin
                            next_s.lsbFirst = wd[CFGA_LSB] || wd[CFGA_LSB_MIR];
                            next_s.ascend   = wd[CFGA_ASC] || wd[CFGA_ASC_MIR];
                        end
                    end
                    ADDR_CFG_B: begin
                        next_s.dpReset = wd[CFGB_DP_RST];
                    end
                    ADDR_CHIP_CFG: begin
                        if (s.chanA) begin
                            next_s.powerMode[PWR_LO] = wd[1:0];
                        end
                        if (s.chanB) begin
                            next_s.powerMode[PWR_HI] = wd[1:0];
                        end
                    end
                    ADDR_CHAN_IDX: begin
                        next_s.chanA = wd[CHAN_A_BIT];
                        next_s.chanB = wd[CHAN_B_BIT];
                    end
                    ADDR_SAMPLE_MODE: begin
                        next_s.sampleMode = wd;
                    end
                    default: begin
                        next_s.rdData = s.rdData;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= CORE_RST;
        end else begin
            s <= next_s;
        end
    end

    // Link logic is held in reset between frames and during recovery
    assign linkRstN = nrst & ~s.linkHold;
    assign txRstN   = linkRstN & ~port_select_n;

    assign lk.rdData = s.rdData;
    assign lk.cfgLsb = s.lsbFirst;
    assign lk.cfgAsc = s.ascend;

    spi_link_rx rxShift (
        .sclk          (sclk),
        .resetN        (linkRstN),
        .port_select_n (port_select_n),
        .sdioIn        (sdioIn),
        .lk            (lk.rx)
    );

    spi_link_tx txDrive (
        .sclk    (sclk),
        .resetN  (txRstN),
        .lk      (lk.tx),
        .sdioOut (sdioOut),
        .sdioOe  (sdioOe)
    );

    assign secondaryEn   = s.secondaryEn;
    assign recoveryBusy  = s.recovering;
    assign datapathReset = s.dpReset;
    assign sampleMode    = s.sampleMode;
    assign powerModeA    = s.powerMode[PWR_LO];
    assign powerModeB    = s.powerMode[PWR_HI];
endmodule

// file: hw/spi_link_if.sv
/*
 * Signals between the system-clock register core and the serial-clock
 * shifters. Requests toggle reqTgl; the bundle stays still until the next toggle.
 */
`timescale 1ns/1ns
interface spi_link_if;
    import spi_cfg_pkg::*;

    logic              reqTgl;
    logic              reqWrite;
    logic [ADDR_W-1:0] reqAddr;
    logic [DATA_W-1:0] reqData;
    logic [DATA_W-1:0] rdData;
    logic              cfgLsb;
    logic              cfgAsc;
    logic              lsbLink;
    logic              driveEn;
    logic [2:0]        bitIdx;

    modport core (input reqTgl, reqWrite, reqAddr, reqData, output rdData, cfgLsb, cfgAsc);
    modport rx   (output reqTgl, reqWrite, reqAddr, reqData, lsbLink, driveEn, bitIdx, input cfgLsb, cfgAsc);
    modport tx   (input rdData, lsbLink, driveEn, bitIdx);
endinterface

// file: hw/spi_link_rx.sv
/*
 * Rising-edge serial shifter: instruction, address, write data and
 * address stepping, all on the serial clock.
 * Assumes resetN is held low between frames and during soft reset recovery.
 */
`timescale 1ns/1ns
module spi_link_rx (
    input  wire logic  sclk,
    input  wire logic  resetN,
    input  wire logic  port_select_n,
    input  wire logic  sdioIn,
    spi_link_if.rx     lk
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic              lsbS1;
        logic              lsbS2;
        logic              ascS1;
        logic              ascS2;
        logic [CNT_W-1:0]  cnt;
        logic              instrDone;
        logic              isRead;
        logic [ADDR_W-1:0] shift;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wbyte;
        logic              reqTgl;
        logic              reqWrite;
        logic [ADDR_W-1:0] reqAddr;
        logic [DATA_W-1:0] reqData;
        logic              driveEn;
    } rx_state_t;

    rx_state_t s;
    rx_state_t next_s;
    logic [ADDR_W-1:0] stepAddr;

    always_comb begin
        next_s = s;
        next_s.lsbS1 = lk.cfgLsb;
        next_s.lsbS2 = s.lsbS1;
        next_s.ascS1 = lk.cfgAsc;
        next_s.ascS2 = s.ascS1;
        stepAddr = s.ascS2 ? s.addr + 15'h0001 : s.addr - 15'h0001;
        if (!port_select_n) begin
            if (!s.instrDone) begin
                next_s.shift = {s.shift[ADDR_W-2:0], sdioIn};
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == INSTR_LAST) begin
                    next_s.cnt = '0;
                    next_s.instrDone = 1'b1;
                    next_s.isRead = (s.shift[ADDR_W-1] == READ_FLAG);
                    next_s.addr = {s.shift[ADDR_W-2:0], sdioIn};
                    if (s.shift[ADDR_W-1] == READ_FLAG) begin
                        next_s.reqTgl = ~s.reqTgl;
                        next_s.reqWrite = 1'b0;
                        next_s.reqAddr = {s.shift[ADDR_W-2:0], sdioIn};
                        next_s.driveEn = 1'b1;
                    end
                end
            end else begin
                next_s.cnt = s.cnt + 4'h1;
                next_s.wbyte = s.lsbS2 ? {sdioIn, s.wbyte[DATA_W-1:1]} : {s.wbyte[DATA_W-2:0], sdioIn};
                if (s.cnt == BYTE_LAST) begin
                    next_s.cnt = '0;
                    next_s.addr = stepAddr;
                    next_s.reqTgl = ~s.reqTgl;
                    if (s.isRead) begin
                        next_s.reqWrite = 1'b0;
                        next_s.reqAddr = stepAddr;
                    end else begin
                        next_s.reqWrite = 1'b1;
                        next_s.reqAddr = s.addr;
                        next_s.reqData = next_s.wbyte;
                    end
                end
            end
        end
    end

    always_ff @(posedge sclk or negedge resetN) begin
        if (!resetN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign lk.reqTgl   = s.reqTgl;
    assign lk.reqWrite = s.reqWrite;
    assign lk.reqAddr  = s.reqAddr;
    assign lk.reqData  = s.reqData;
    assign lk.lsbLink  = s.lsbS2;
    assign lk.driveEn  = s.driveEn;
    assign lk.bitIdx   = s.cnt[2:0];
endmodule

// file: hw/spi_link_tx.sv
/*
 * Falling-edge read-data driver for the shared data pin.
 * Assumes resetN is low whenever the select is high, so the pin floats then.
 */
`timescale 1ns/1ns
module spi_link_tx (
    input  wire logic  sclk,
    input  wire logic  resetN,
    spi_link_if.tx     lk,
    output logic       sdioOut,
    output logic       sdioOe
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic out;
        logic oe;
    } tx_state_t;

    tx_state_t s;
    tx_state_t next_s;

    always_comb begin
        next_s.oe  = lk.driveEn;
        next_s.out = lk.rdData[lk.lsbLink ? lk.bitIdx : 3'(BYTE_LAST[2:0] - lk.bitIdx)];
    end

    always_ff @(negedge sclk or negedge resetN) begin
        if (!resetN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sdioOut = s.out;
    assign sdioOe  = s.oe;
endmodule

// file: testbench/spi_config_port_props.sv
/* Checker for the serial configuration port top-level pins.
   Assumes one clk_sys domain reset by nrst, bound below. */
`timescale 1ns/1ns
module spi_config_port_props #(
    parameter int RECOVERY_CYCLES = spi_cfg_pkg::RECOVERY_CYCLES_DFLT
) (
    input wire logic                             clk_sys,
    input wire logic                             nrst,
    input wire logic                             port_select_n,
    input wire logic                             sdioOe,
    input wire logic                             secondaryEn,
    input wire logic                             recoveryBusy,
    input wire logic                             datapathReset,
    input wire logic [spi_cfg_pkg::DATA_W-1:0]   sampleMode,
    input wire logic [1:0]                       powerModeA,
    input wire logic [1:0]                       powerModeB
);
    import spi_cfg_pkg::*;

    logic [7:0]  hiCnt;
    logic [19:0] busyCnt;

    // Cycles of select high in a row, and length of the running recovery
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hiCnt <= 8'h00;
            busyCnt <= 20'h00000;
        end else begin
            hiCnt <= !port_select_n ? 8'h00 : hiCnt + {7'h00, hiCnt != 8'hff};
            busyCnt <= recoveryBusy ? busyCnt + 20'h00001 : 20'h00000;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_OE_IDLE: assert property (port_select_n |-> !sdioOe)
        else $error("data pin driven with select high");
    AST_SEC_OFF: assert property ($fell(port_select_n) |-> ##[1:6] !secondaryEn)
        else $error("secondary use kept during a frame");
    AST_SEC_ON: assert property (hiCnt == 8'h6e |-> secondaryEn)
        else $error("secondary use missing after long idle");
    AST_DP_PULSE: assert property (datapathReset |=> !datapathReset)
        else $error("datapath reset longer than one cycle");
    AST_DP_QUIET: assert property ($rose(datapathReset) |-> !recoveryBusy)
        else $error("datapath reset during recovery");
    AST_RECOV_LEN: assert property ($fell(recoveryBusy) |-> busyCnt == RECOVERY_CYCLES)
        else $error("recovery length wrong");
    AST_RECOV_DFLT: assert property ($rose(recoveryBusy) |-> ##[0:2]
        (sampleMode == SAMPLE_MODE_RST && powerModeA == 2'b00 && powerModeB == 2'b00))
        else $error("registers not at defaults in recovery");
    AST_BUSY_FROZEN: assert property (recoveryBusy && $past(recoveryBusy) |-> $stable(sampleMode))
        else $error("register changed during recovery");
    AST_IDLE_FROZEN: assert property (port_select_n [*8] |-> $stable(sampleMode) && $stable(powerModeB))
        else $error("register changed with select high");
endmodule

bind spi_config_port spi_config_port_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) i_spi_config_port_props (
    .clk_sys(clk_sys), .nrst(nrst), .port_select_n(port_select_n), .sdioOe(sdioOe),
    .secondaryEn(secondaryEn), .recoveryBusy(recoveryBusy), .datapathReset(datapathReset),
    .sampleMode(sampleMode), .powerModeA(powerModeA), .powerModeB(powerModeB)
);

// file: testbench/spi_host_model.sv
/* Host on the three-wire port: frames, stalls and read capture.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ns
module spi_host_model (
    output logic       sclk,
    output logic       port_select_n,
    output logic       sdioIn,
    input  wire logic  sdioOut,
    input  wire logic  sdioOe,
    output logic [7:0] rdByte,
    output logic       rdTgl
);
    logic       hostOe;
    logic       hostBit;
    logic       floatBit;
    logic       lsbFirst;
    logic [7:0] txQ[$];

    // A released line flips every bit instead of keeping the last level
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : floatBit);

    initial begin
        sclk = 1'b0;
        port_select_n = 1'b1;
        hostOe = 1'b0;
        hostBit = 1'b0;
        floatBit = 1'b0;
        lsbFirst = 1'b0;
        rdByte = 8'h00;
        rdTgl = 1'b0;
    end

    // Falling edge launches a bit, rising edge samples it
    task automatic clk_bit(input logic b, input logic drv, output logic s);
        sclk = 1'b0;
        hostOe = drv;
        hostBit = b;
        floatBit = ~floatBit;
        #3;
        sclk = 1'b1;
        s = sdioIn;
        #3;
    endtask

    task automatic frame(input logic rd, input logic [14:0] addr, input int n, input int stallNs);
        logic [15:0] ins;
        logic [7:0]  d;
        logic        s;
        ins = {rd, addr};
        d = 8'h00;
        port_select_n = 1'b0;
        #60;
        for (int i = 15; i >= 0; i--) begin
            clk_bit(ins[i], 1'b1, s);
        end
        #100;
        for (int k = 0; k < n; k++) begin
            if (!rd) begin
                d = txQ.pop_front();
            end
            for (int i = 0; i < 8; i++) begin
                clk_bit(d[lsbFirst ? i : 7 - i], !rd, s);
                d[lsbFirst ? i : 7 - i] = s;
            end
            if (rd) begin
                rdByte = d;
                rdTgl = ~rdTgl;
            end
            if (stallNs > 0 && k < n - 1) begin
                port_select_n = 1'b1;
                #(stallNs);
                port_select_n = 1'b0;
            end
            #100;
        end
        hostOe = 1'b0;
        port_select_n = 1'b1;
        #1200;
    endtask

    // Clocks a whole write with select high
    task automatic ghost(input logic [23:0] bits);
        logic s;
        for (int i = 23; i >= 0; i--) begin
            clk_bit(bits[i], 1'b1, s);
        end
        hostOe = 1'b0;
    endtask
endmodule

// file: testbench/tb_top.sv
/* Self-checking bench for the configuration port with a host model.
   Assumes the checker is bound to the port by its own file. */
`timescale 1ns/1ns
module tb_top;
    import spi_cfg_pkg::*;

    localparam int RECOV = 50;
    localparam int LIMIT = 20000;

    typedef struct {
        string      what;
        logic [7:0] exp;
    } note_t;

    logic              clk_sys, nrst, sclk, port_select_n, sdioIn, sdioOut, sdioOe;
    logic              secondaryEn, recoveryBusy, datapathReset, rdTgl;
    logic [DATA_W-1:0] sampleMode;
    logic [1:0]        powerModeA, powerModeB;
    logic [7:0]        rdByte, v;
    note_t             notes[$];
    note_t             note;
    int                errors, compares, cycles, dpCount, busyCount;

    spi_config_port #(.RECOVERY_CYCLES(RECOV)) i_spi_config_port (
        .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .port_select_n(port_select_n),
        .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .secondaryEn(secondaryEn),
        .recoveryBusy(recoveryBusy), .datapathReset(datapathReset), .sampleMode(sampleMode),
        .powerModeA(powerModeA), .powerModeB(powerModeB)
    );

    spi_host_model i_spi_host_model (
        .sclk(sclk), .port_select_n(port_select_n), .sdioIn(sdioIn), .sdioOut(sdioOut),
        .sdioOe(sdioOe), .rdByte(rdByte), .rdTgl(rdTgl)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        i_spi_host_model.txQ.push_back(d);
        i_spi_host_model.frame(1'b0, a, 1, 0);
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        notes.push_back('{$sformatf("reg %h", a), e});
        i_spi_host_model.frame(1'b1, a, 1, 0);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (datapathReset === 1'b1) begin
            dpCount++;
        end
        if (recoveryBusy === 1'b1) begin
            busyCount++;
        end
        if (cycles == LIMIT) begin
            cmp("cycle limit", 8'h00, 8'h01);
            stop_test();
        end
    end

    always @(posedge sclk) begin
        if (i_spi_host_model.hostOe === 1'b1 && port_select_n === 1'b0) begin
            cmp("sdioOe", 8'h00, {7'h00, sdioOe});
        end
    end

    // Each captured read byte takes the oldest expectation
    initial begin
        wait (nrst === 1'b1);
        forever begin
            @(rdTgl);
            note = notes.pop_front();
            cmp(note.what, note.exp, rdByte);
        end
    end

    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        errors = 0;
        compares = 0;
        cycles = 0;
        dpCount = 0;
        busyCount = 0;
        void'($urandom(32'hc50021fd));
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        #100;
        cmp("sampleMode", SAMPLE_MODE_RST, sampleMode);
        cmp("secondaryEn", 8'h01, {7'h00, secondaryEn});
        rd(ADDR_SAMPLE_MODE, SAMPLE_MODE_RST);
        rd(ADDR_CFG_A, 8'h00);
        notes.push_back('{"idx", 8'h03});
        notes.push_back('{"reg 0007", 8'h00});
        notes.push_back('{"reg 0006", 8'h00});
        i_spi_host_model.frame(1'b1, ADDR_CHAN_IDX, 3, 0);
        v = 8'($urandom);
        wr(ADDR_SAMPLE_MODE, v);
        cmp("sampleMode", v, sampleMode);
        wr(ADDR_CHAN_IDX, 8'h01);
        wr(ADDR_CHIP_CFG, 8'h01);
        wr(ADDR_CHAN_IDX, 8'h02);
        wr(ADDR_CHIP_CFG, 8'h02);
        cmp("powerModeA", 8'h01, {6'h00, powerModeA});
        rd(ADDR_CHIP_CFG, 8'h02);
        rd(ADDR_SAMPLE_MODE, v);
        wr(ADDR_CHAN_IDX, 8'h03);
        rd(ADDR_CHIP_CFG, 8'h01);
        wr(ADDR_CFG_A, 8'h04);
        rd(ADDR_CFG_A, 8'h24);
        i_spi_host_model.txQ.push_back(8'h00);
        i_spi_host_model.txQ.push_back(8'h03);
        i_spi_host_model.frame(1'b0, ADDR_CFG_B, 2, 200);
        cmp("powerModeA", 8'h03, {6'h00, powerModeA});
        cmp("powerModeB", 8'h03, {6'h00, powerModeB});
        wr(ADDR_CFG_B, 8'h02);
        rd(ADDR_CFG_B, 8'h00);
        cmp("datapathReset", 8'h01, 8'(dpCount));
        wr(ADDR_CFG_A, 8'h06);
        i_spi_host_model.lsbFirst = 1'b1;
        v = 8'($urandom);
        wr(ADDR_SAMPLE_MODE, v);
        cmp("sampleMode", v, sampleMode);
        rd(ADDR_SAMPLE_MODE, v);
        rd(ADDR_CFG_A, 8'h66);
        wr(ADDR_CFG_A, 8'h81);
        i_spi_host_model.lsbFirst = 1'b0;
        cmp("recoveryBusy", 8'(RECOV), 8'(busyCount));
        cmp("sampleMode", SAMPLE_MODE_RST, sampleMode);
        cmp("powerModeB", 8'h00, {6'h00, powerModeB});
        rd(ADDR_CFG_A, 8'h00);
        rd(ADDR_CHAN_IDX, 8'h03);
        i_spi_host_model.ghost({1'b0, ADDR_SAMPLE_MODE, 8'h5a});
        #200;
        cmp("sampleMode", SAMPLE_MODE_RST, sampleMode);
        wr(ADDR_SAMPLE_MODE, 8'h3c);
        cmp("sampleMode", 8'h3c, sampleMode);
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        #100;
        cmp("sampleMode", SAMPLE_MODE_RST, sampleMode);
        rd(ADDR_CHIP_CFG, 8'h00);
        #100;
        cmp("notes left", 8'h00, 8'(notes.size()));
        stop_test();
    end
endmodule
